/* cpu_bus_model.sv */
// cpu stand-in driving the byte wide register port
`default_nettype none
module cpu_bus_model
  import dual_timer_pkg::*;
(
  // clock and returned data
  input  wire logic              core_clk,
  input  wire logic [7:0]        bus_rdata,
  // strobes, select and write data
  output var  logic [ADDR_W-1:0] bus_addr,
  output var  logic              bus_wr,
  output var  logic              bus_rd,
  output var  logic [7:0]        bus_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {bus_addr, bus_wr, bus_rd, bus_wdata} = '0;
  // one strobe cycle per byte; idle data shows the inverse of the last byte
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge core_clk) #1;
    {bus_wr, bus_rd, bus_addr, bus_wdata} = {w, ~w, a, d};
    @(posedge core_clk) #1;
    {bus_wr, bus_rd, bus_wdata} = {2'b00, ~d};
    q = bus_rdata;
  endtask : access
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] q);
    access(1'b0, a, ~bus_wdata, q);
  endtask : rd
  // lone bytes corrupt a sixteen bit value, so upper always goes first
  task automatic wr16(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(ADDR_W'(a + 1), v[7:0]);
  endtask : wr16
endmodule : cpu_bus_model
`default_nettype wire

/* dual_mode_compare_timer.sv */
// sixteen bit compare timer that splits into two eight bit timers
//
// Function
// - upper byte write goes to temp latch; lower write loads both halves together.
// - counter upper read returns upper, latches lower; lower read returns latch.
// - compare register bytes read back directly, latch unused.
// - eight bit mode accepts byte accesses to either half in any order.
// - high select top bit 0 means one sixteen bit counter, 1 means two.
// - reset gives count zero, compare all ones, control and status zero.
// - clock select picks core clock over 32, 16, 4 or 2.
// - low select top bit 0 counts event input edges of selected polarity.
// - sixteen bit match sets high flag, toggles pin, requests irq, optionally clears.
// - sixteen bit wrap sets high wrap flag; irq needs wrap enable and master enable.
// - eight bit mode matches each half separately with flag, pin, irq, clear.
// - eight bit wrap of a half sets its flag; irq needs both enables.
// - each compare pin drives its level bit and inverts on every match without a control write in that cycle.
// - match fires as the counter leaves the equal count on next tick.
// - counter halts when not running; registers always keep their contents.
// - control write together with match loads written level instead of toggling.
// - compare write in the match cycle suppresses that match only.
// - match happens only on the half's own tick; stopped clock means none.
// - sixteen bit mode also sets low flags from the lower byte.
// - counter half write in its wrap cycle suppresses the wrap flag.
// - flags set by hardware only; cleared by writing 0 after reading 1.
// - writing a level bit changes the pin right after the write.
`default_nettype none

module dual_mode_compare_timer
  import dual_timer_pkg::*;
(
  // clock, reset, enables
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              count_run,
  // byte wide register port
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  input  wire logic [7:0]        bus_wdata,
  output logic      [7:0]        bus_rdata,
  // event input and interrupt controller bits
  input  wire logic              event_count_input,
  input  wire logic              event_edge_sel,
  input  wire logic              high_irq_master_en,
  input  wire logic              low_irq_master_en,
  // pins and interrupt requests
  output logic                   high_compare_out_pin,
  output logic                   low_compare_out_pin,
  output logic                   high_irq_req,
  output logic                   low_irq_req
);

  // ************************************************************
  // decode helper
  // ************************************************************
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] sel);
    hit = strobe && (addr == sel);
  endfunction : hit

  // ************************************************************
  // state
  // ************************************************************
  logic [15:0] count_value_reg;
  logic [15:0] compare_value_reg;
  logic [7:0]  timer_control_reg;
  logic [7:0]  timer_control_status_reg;
  logic [7:0]  temp_reg;
  logic [7:0]  flag_armed_reg;
  logic [7:0]  bus_rdata_reg;
  logic        high_pin_reg;
  logic        low_pin_reg;
  logic        high_irq_reg;
  logic        low_irq_reg;

  logic [15:0] count_value_next;
  logic [15:0] compare_value_next;
  logic [7:0]  status_next;
  logic [7:0]  status_set;
  logic [7:0]  temp_next;
  logic [7:0]  rdata_next;
  logic        high_pin_next;
  logic        low_pin_next;

  // ************************************************************
  // bus strobes
  // ************************************************************
  // strobes carry no clk_en; every flop that uses them does
  logic wr_count_upper, wr_count_lower, wr_compare_upper, wr_compare_lower;
  logic wr_control, wr_status, rd_count_upper, rd_status;

  assign wr_count_upper   = hit(bus_wr, bus_addr, SEL_COUNT_UPPER);
  assign wr_count_lower   = hit(bus_wr, bus_addr, SEL_COUNT_LOWER);
  assign wr_compare_upper = hit(bus_wr, bus_addr, SEL_COMPARE_UPPER);
  assign wr_compare_lower = hit(bus_wr, bus_addr, SEL_COMPARE_LOWER);
  assign wr_control       = hit(bus_wr, bus_addr, SEL_CONTROL);
  assign wr_status        = hit(bus_wr, bus_addr, SEL_STATUS);
  assign rd_count_upper   = hit(bus_rd, bus_addr, SEL_COUNT_UPPER);
  assign rd_status        = hit(bus_rd, bus_addr, SEL_STATUS);

  // ************************************************************
  // mode and field views
  // ************************************************************
  logic       split_mode;
  logic [1:0] high_sel;
  logic [1:0] low_sel;
  logic       low_internal;
  logic [7:0] count_upper_half;
  logic [7:0] count_lower_half;
  logic [7:0] compare_upper_half;
  logic [7:0] compare_lower_half;

  assign split_mode         = timer_control_reg[CTL_HIGH_SEL_TOP];
  assign high_sel           = timer_control_reg[CTL_HIGH_SEL_LO +: 2];
  assign low_sel            = timer_control_reg[CTL_LOW_SEL_LO +: 2];
  assign low_internal       = timer_control_reg[CTL_LOW_SEL_TOP];
  assign count_upper_half   = count_value_reg[15:8];
  assign count_lower_half   = count_value_reg[7:0];
  assign compare_upper_half = compare_value_reg[15:8];
  assign compare_lower_half = compare_value_reg[7:0];

  // ************************************************************
  // count ticks
  // ************************************************************
  // one shared prescaler; each half picks its own tap
  logic [3:0] div_tick;
  logic       event_tick;
  logic       low_tick;
  logic       high_tick;

  timer_tick_gen u_tick (
    .core_clk          (core_clk),
    .sys_rst           (sys_rst),
    .clk_en            (clk_en),
    .event_count_input (event_count_input),
    .event_edge_sel    (event_edge_sel),
    .div_tick          (div_tick),
    .event_tick        (event_tick)
  );

  // counting stops in the low power states; the registers stay put
  assign low_tick  = count_run && (low_internal ? div_tick[low_sel] : event_tick);
  assign high_tick = count_run && div_tick[high_sel];

  // ************************************************************
  // which halves are written this cycle
  // ************************************************************
  // in sixteen bit mode the upper half only moves when the lower byte commits
  logic cnt_lo_wr, cnt_hi_wr, cmp_lo_wr, cmp_hi_wr;

  assign cnt_lo_wr = wr_count_lower;
  assign cnt_hi_wr = split_mode ? wr_count_upper : wr_count_lower;
  assign cmp_lo_wr = wr_compare_lower;
  assign cmp_hi_wr = split_mode ? wr_compare_upper : wr_compare_lower;

  // ************************************************************
  // compare match: fires on the tick that leaves the equal count
  // ************************************************************
  logic lo_equal, hi_equal, low_match, high_match;

  // equality alone does nothing; only a tick while equal counts
  assign lo_equal  = (count_lower_half == compare_lower_half);
  assign hi_equal  = (count_upper_half == compare_upper_half);
  // a compare write in the same cycle kills this match only
  assign low_match = low_tick && lo_equal && !cmp_lo_wr;
  assign high_match = split_mode ? (high_tick && hi_equal && !cmp_hi_wr)
                                 : (low_tick && lo_equal && hi_equal && !cmp_lo_wr);

  // ************************************************************
  // clear on match
  // ************************************************************
  logic clear_all, clear_lo, clear_hi;

  // sixteen bit mode clears both halves on the high clear bit alone
  assign clear_all = !split_mode && high_match && timer_control_status_reg[ST_HIGH_CLR];
  assign clear_lo  = clear_all ||
                     (split_mode && low_match && timer_control_status_reg[ST_LOW_CLR]);
  assign clear_hi  = clear_all ||
                     (split_mode && high_match && timer_control_status_reg[ST_HIGH_CLR]);

  // ************************************************************
  // wrap detection; a write to the half in the same cycle hides it
  // ************************************************************
  // high_step carries the low byte into the upper half in sixteen bit mode
  logic lo_full, hi_full, low_wrap, high_wrap, high_step;

  assign lo_full   = (count_lower_half == BYTE_ALL_ONES);
  assign hi_full   = (count_upper_half == BYTE_ALL_ONES);
  assign low_wrap  = low_tick && lo_full && !clear_lo && !cnt_lo_wr;
  assign high_step = split_mode ? high_tick : (low_tick && lo_full);
  assign high_wrap = split_mode ? (high_tick && hi_full && !clear_hi && !cnt_hi_wr)
                                : (low_wrap && hi_full && !cnt_hi_wr);

  // ************************************************************
  // counter next value
  // ************************************************************
  // a bus write beats a clear, and a clear beats a count step
  assign count_value_next[7:0] =
    cnt_lo_wr ? bus_wdata :
    clear_lo  ? BYTE_ZERO :
    low_tick  ? count_lower_half + 8'h01 :
                count_lower_half;
  assign count_value_next[15:8] =
    cnt_hi_wr ? (split_mode ? bus_wdata : temp_reg) :
    clear_hi  ? BYTE_ZERO :
    high_step ? count_upper_half + 8'h01 :
                count_upper_half;

  // ************************************************************
  // compare next value
  // ************************************************************
  // only bus writes move the compare value
  assign compare_value_next[7:0]  = cmp_lo_wr ? bus_wdata : compare_lower_half;
  assign compare_value_next[15:8] = cmp_hi_wr ? (split_mode ? bus_wdata : temp_reg)
                                              : compare_upper_half;

  // ************************************************************
  // temporary latch, used only in sixteen bit mode
  // ************************************************************
  // one latch serves both directions, so reads and writes must not interleave
  assign temp_next =
    (!split_mode && (wr_count_upper || wr_compare_upper)) ? bus_wdata :
    (!split_mode && rd_count_upper) ? count_lower_half :
                                      temp_reg;

  // ************************************************************
  // status flags
  // ************************************************************
  assign status_set[ST_HIGH_WRAP]    = high_wrap;
  assign status_set[ST_HIGH_MATCH]   = high_match;
  // control bits in the status register never set themselves
  assign status_set[ST_HIGH_WRAP_IE] = 1'b0;
  assign status_set[ST_HIGH_CLR]     = 1'b0;
  assign status_set[ST_LOW_WRAP]     = low_wrap;
  assign status_set[ST_LOW_MATCH]    = low_match;
  assign status_set[ST_LOW_WRAP_IE]  = 1'b0;
  assign status_set[ST_LOW_CLR]      = 1'b0;

  // flags: set wins over clear, and clear needs a prior read of one
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_status
      if (FLAG_MASK[gi]) begin : g_flag
        assign status_next[gi] = status_set[gi] ||
          (timer_control_status_reg[gi] &&
           !(wr_status && flag_armed_reg[gi] && !bus_wdata[gi]));
      end else begin : g_ctl
        assign status_next[gi] = wr_status ? bus_wdata[gi] : timer_control_status_reg[gi];
      end
    end
  endgenerate

  // ************************************************************
  // compare output pins
  // ************************************************************
  // the written level takes priority over a toggle in the same cycle
  assign high_pin_next = wr_control ? bus_wdata[CTL_HIGH_LEVEL] :
                         high_match ? !high_pin_reg : high_pin_reg;
  assign low_pin_next  = wr_control ? bus_wdata[CTL_LOW_LEVEL] :
                         low_match  ? !low_pin_reg : low_pin_reg;

  // ************************************************************
  // read data
  // ************************************************************
  // lower count byte comes from the latch only in sixteen bit mode
  always_comb begin
    case (bus_addr)
      SEL_COUNT_UPPER:   rdata_next = count_upper_half;
      SEL_COUNT_LOWER:   rdata_next = split_mode ? count_lower_half : temp_reg;
      SEL_COMPARE_UPPER: rdata_next = compare_upper_half;
      SEL_COMPARE_LOWER: rdata_next = compare_lower_half;
      SEL_CONTROL:       rdata_next = timer_control_reg;
      SEL_STATUS:        rdata_next = timer_control_status_reg;
      default:           rdata_next = 8'h00;
    endcase
  end

  // ************************************************************
  // counter, compare and control registers
  // ************************************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_value_reg   <= COUNT_RESET;
      compare_value_reg <= COMPARE_RESET;
      timer_control_reg <= CONTROL_RESET;
      temp_reg          <= 8'h00;
    end else if (clk_en) begin
      count_value_reg   <= count_value_next;
      compare_value_reg <= compare_value_next;
      timer_control_reg <= wr_control ? bus_wdata : timer_control_reg;
      temp_reg          <= temp_next;
    end
  end

  // ************************************************************
  // status register and read arming
  // ************************************************************
  // a read arms the flags it saw set; any status write disarms them
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_control_status_reg <= STATUS_RESET;
      flag_armed_reg           <= 8'h00;
    end else if (clk_en) begin
      timer_control_status_reg <= status_next;
      flag_armed_reg           <= rd_status ? (timer_control_status_reg & FLAG_MASK) :
                                  wr_status ? 8'h00 : flag_armed_reg;
    end
  end

  // ************************************************************
  // output flops
  // ************************************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_rdata_reg <= 8'h00;
      high_pin_reg  <= 1'b0;
      low_pin_reg   <= 1'b0;
      high_irq_reg  <= 1'b0;
      low_irq_reg   <= 1'b0;
    end else if (clk_en) begin
      bus_rdata_reg <= bus_rd ? rdata_next : bus_rdata_reg;
      high_pin_reg  <= high_pin_next;
      low_pin_reg   <= low_pin_next;
      // request level follows the flags after the update
      high_irq_reg  <= high_irq_master_en && (status_next[ST_HIGH_MATCH] ||
                       (status_next[ST_HIGH_WRAP] && status_next[ST_HIGH_WRAP_IE]));
      low_irq_reg   <= low_irq_master_en && (status_next[ST_LOW_MATCH] ||
                       (status_next[ST_LOW_WRAP] && status_next[ST_LOW_WRAP_IE]));
    end
  end

  // outputs are plain flop copies, no logic between flop and pin
  assign bus_rdata            = bus_rdata_reg;
  assign high_compare_out_pin = high_pin_reg;
  assign low_compare_out_pin  = low_pin_reg;
  assign high_irq_req         = high_irq_reg;
  assign low_irq_req          = low_irq_reg;

endmodule : dual_mode_compare_timer

`default_nettype wire

/* dual_mode_compare_timer_tb.sv */
// self-checking bench for the dual mode compare timer
`default_nettype none
module dual_mode_compare_timer_tb
  import dual_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              core_clk, sys_rst, clk_en, count_run, event_count_input, event_edge_sel;
  logic              high_irq_master_en, low_irq_master_en, bus_wr, bus_rd;
  logic              high_compare_out_pin, low_compare_out_pin, high_irq_req, low_irq_req;
  logic [ADDR_W-1:0] bus_addr;
  logic [7:0]        bus_wdata, bus_rdata;
  int                err_count = 0, compares = 0;
  dual_mode_compare_timer uut (.*);
  cpu_bus_model           cpu (.*);
  // 40 ns clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu.rd(a, d);
    chk(d, exp);
  endtask : rchk
  // bounded wait, so a dead pin cannot hang the run
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 60 && s !== 1'b1; i++) @(posedge core_clk) #1;
  endtask : wait_hi
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // watchdog well past the hundred or so cycles the tests need
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    {sys_rst, clk_en, event_edge_sel} = 3'b111;
    {count_run, event_count_input, high_irq_master_en, low_irq_master_en} = 4'h0;
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    rchk(SEL_COMPARE_UPPER, 8'hFF);
    rchk(SEL_CONTROL, 8'h00);
    rchk(SEL_STATUS, 8'h00);
    count_run = 1'b1;
    // three rising edges, each level held two cycles
    repeat (6) begin
      repeat (2) @(posedge core_clk);
      #1 event_count_input = ~event_count_input;
    end
    count_run = 1'b0;
    rchk(SEL_COUNT_UPPER, 8'h00);
    rchk(SEL_COUNT_LOWER, 8'h03);
    $display("reset and event count test done");
    cpu.wr16(SEL_COUNT_UPPER, 16'hAA55);
    rchk(SEL_COUNT_UPPER, 8'hAA);
    rchk(SEL_COMPARE_LOWER, 8'hFF);
    rchk(SEL_COUNT_LOWER, 8'h55);
    cpu.wr16(SEL_COMPARE_UPPER, 16'h0002);
    cpu.wr16(SEL_COUNT_UPPER, 16'h0000);
    cpu.wr(SEL_STATUS, 8'h10);
    cpu.wr(SEL_CONTROL, 8'h07);
    high_irq_master_en = 1'b1;
    count_run = 1'b1;
    wait_hi(high_compare_out_pin);
    count_run = 1'b0;
    chk({high_compare_out_pin, high_irq_req, 6'h00}, 8'hC0);
    rchk(SEL_STATUS, 8'h54);
    cpu.wr(SEL_STATUS, 8'h10);
    rchk(SEL_STATUS, 8'h10);
    cpu.wr(SEL_STATUS, 8'hFF);
    rchk(SEL_STATUS, 8'h33);
    chk({7'h00, high_irq_req}, 8'h00);
    cpu.wr(SEL_CONTROL, 8'h08);
    chk({6'h00, high_compare_out_pin, low_compare_out_pin}, 8'h01);
    $display("sixteen bit match test done");
    cpu.wr(SEL_CONTROL, 8'h47);
    cpu.wr(SEL_COUNT_LOWER, 8'hFE);
    cpu.wr(SEL_COUNT_UPPER, 8'h12);
    rchk(SEL_COUNT_LOWER, 8'hFE);
    rchk(SEL_COUNT_UPPER, 8'h12);
    low_irq_master_en = 1'b1;
    count_run = 1'b1;
    wait_hi(low_irq_req);
    count_run = 1'b0;
    chk({7'h00, low_irq_req}, 8'h01);
    rchk(SEL_STATUS, 8'h3B);
    cpu.wr(SEL_STATUS, 8'h33);
    chk({7'h00, low_irq_req}, 8'h00);
    $display("eight bit wrap test done");
    event_edge_sel = 1'b0;
    cpu.wr(SEL_CONTROL, 8'h43);
    cpu.wr(SEL_COUNT_LOWER, 8'h01);
    count_run = 1'b1;
    // two falling edges: 01 to 02, then the match at 02 clears the half
    repeat (4) begin
      repeat (2) @(posedge core_clk);
      #1 event_count_input = ~event_count_input;
    end
    @(posedge core_clk) #1 count_run = 1'b0;
    chk({6'h00, high_compare_out_pin, low_compare_out_pin}, 8'h01);
    chk({7'h00, low_irq_req}, 8'h01);
    rchk(SEL_STATUS, 8'h37);
    rchk(SEL_COUNT_LOWER, 8'h00);
    $display("falling edge match test done");
    end_sim();
  end
endmodule : dual_mode_compare_timer_tb
`default_nettype wire

/* dual_timer_pkg.sv */
// constants shared by the dual mode compare timer and its tick generator
`default_nettype none

package dual_timer_pkg;

  // ************************************************************
  // register select codes on the byte bus
  // ************************************************************
  localparam int unsigned ADDR_W           = 3;
  localparam logic [2:0]  SEL_COUNT_UPPER   = 3'h0;
  localparam logic [2:0]  SEL_COUNT_LOWER   = 3'h1;
  localparam logic [2:0]  SEL_COMPARE_UPPER = 3'h2;
  localparam logic [2:0]  SEL_COMPARE_LOWER = 3'h3;
  localparam logic [2:0]  SEL_CONTROL       = 3'h4;
  localparam logic [2:0]  SEL_STATUS        = 3'h5;

  // ************************************************************
  // timer_control field positions
  // ************************************************************
  localparam int unsigned CTL_HIGH_LEVEL   = 7;
  localparam int unsigned CTL_HIGH_SEL_TOP = 6;
  localparam int unsigned CTL_HIGH_SEL_LO  = 4;
  localparam int unsigned CTL_LOW_LEVEL    = 3;
  localparam int unsigned CTL_LOW_SEL_TOP  = 2;
  localparam int unsigned CTL_LOW_SEL_LO   = 0;

  // ************************************************************
  // timer_control_status field positions
  // ************************************************************
  localparam int unsigned ST_HIGH_WRAP    = 7;
  localparam int unsigned ST_HIGH_MATCH   = 6;
  localparam int unsigned ST_HIGH_WRAP_IE = 5;
  localparam int unsigned ST_HIGH_CLR     = 4;
  localparam int unsigned ST_LOW_WRAP     = 3;
  localparam int unsigned ST_LOW_MATCH    = 2;
  localparam int unsigned ST_LOW_WRAP_IE  = 1;
  localparam int unsigned ST_LOW_CLR      = 0;
  localparam logic [7:0]  FLAG_MASK       = 8'hCC;

  // ************************************************************
  // reset values and counter limits
  // ************************************************************
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  BYTE_ALL_ONES = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  // ************************************************************
  // prescaler: tick masks for /32, /16, /4, /2 (select codes 0..3)
  // ************************************************************
  localparam int unsigned PRESCALE_W = 5;
  localparam logic [4:0]  DIV32_MASK = 5'h1F;
  localparam logic [4:0]  DIV16_MASK = 5'h0F;
  localparam logic [4:0]  DIV4_MASK  = 5'h03;
  localparam logic [4:0]  DIV2_MASK  = 5'h01;

endpackage : dual_timer_pkg

`default_nettype wire

/* timer_checks_properties.sv */
// port assertions for the dual mode compare timer
`default_nettype none
module timer_checks
  import dual_timer_pkg::*;
(
  // clock, reset, run controls and byte port
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              clk_en,
  input wire logic              count_run,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic              bus_wr,
  input wire logic              bus_rd,
  input wire logic [7:0]        bus_wdata,
  input wire logic [7:0]        bus_rdata,
  // enables, pins and requests
  input wire logic              high_irq_master_en,
  input wire logic              low_irq_master_en,
  input wire logic              high_compare_out_pin,
  input wire logic              low_compare_out_pin,
  input wire logic              high_irq_req,
  input wire logic              low_irq_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // taken control write and its level bits
  wire ctl_wr = clk_en && bus_wr && bus_addr == SEL_CONTROL;
  wire hi_lvl = bus_wdata[CTL_HIGH_LEVEL];
  wire lo_lvl = bus_wdata[CTL_LOW_LEVEL];
  rst_quiet_a: assert property ($fell(sys_rst) |-> !high_compare_out_pin && !high_irq_req)
    else $error("outputs not clear after reset");
  rdata_hold_a: assert property (!(clk_en && bus_rd) |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  high_level_a: assert property (ctl_wr |=> high_compare_out_pin == $past(hi_lvl))
    else $error("high pin missed written level");
  low_level_a: assert property (ctl_wr |=> low_compare_out_pin == $past(lo_lvl))
    else $error("low pin missed written level");
  high_pin_halt_a: assert property (!ctl_wr && !(clk_en && count_run) |=>
    $stable(high_compare_out_pin)) else $error("high pin moved while halted");
  low_pin_halt_a: assert property (!ctl_wr && !(clk_en && count_run) |=>
    $stable(low_compare_out_pin)) else $error("low pin moved without a tick");
  high_irq_gate_a: assert property (!high_irq_master_en [*2] |-> !high_irq_req)
    else $error("high request without enable");
  low_irq_gate_a: assert property (!low_irq_master_en [*2] |-> !low_irq_req)
    else $error("low request without enable");
endmodule : timer_checks
bind dual_mode_compare_timer timer_checks u_chk (.*);
`default_nettype wire

/* timer_tick_gen.sv */
// shared prescaler feeding both counter halves, and event edge detector feeding the low half
`default_nettype none

module timer_tick_gen
  import dual_timer_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // event input and polarity
  input  wire logic       event_count_input,
  input  wire logic       event_edge_sel,
  // ticks
  output logic [3:0]      div_tick,
  output logic            event_tick
);

  logic [PRESCALE_W-1:0] prescale_reg;
  logic                  event_prev_reg;
  logic                  event_primed_reg;

  // ************************************************************
  // free running prescaler and event history
  // ************************************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale_reg     <= '0;
      event_prev_reg   <= 1'b0;
      event_primed_reg <= 1'b0;
    end else if (clk_en) begin
      prescale_reg     <= prescale_reg + 1'b1;
      event_prev_reg   <= event_count_input;
      event_primed_reg <= 1'b1;
    end
  end

  // a tick each time the low bits of the prescaler are all ones
  assign div_tick[0] = clk_en && ((prescale_reg & DIV32_MASK) == DIV32_MASK);
  assign div_tick[1] = clk_en && ((prescale_reg & DIV16_MASK) == DIV16_MASK);
  assign div_tick[2] = clk_en && ((prescale_reg & DIV4_MASK) == DIV4_MASK);
  assign div_tick[3] = clk_en && ((prescale_reg & DIV2_MASK) == DIV2_MASK);

  // edge select high counts rising edges, low counts falling edges
  // no edge until one sample is in, so an idle high pin gives no false count
  assign event_tick = clk_en && event_primed_reg &&
                      (event_edge_sel ? (event_count_input && !event_prev_reg)
                                      : (!event_count_input && event_prev_reg));

endmodule : timer_tick_gen

`default_nettype wire
